// ### level_interrupt_controller.sv
// level_interrupt_controller.sv: level interrupt controller with AHB-Lite registers
// assumes: source events, core strobes and program memory share CLK_SYS_I;
// program memory answers a read one cycle after the request.
`timescale 1ns/1ps
`include "level_irq_defines.svh"

module level_interrupt_controller
(
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  // ahb-lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // peripheral source events
  input wire logic [4:0] SRC_EVENT_I,
  // core side
  input wire level_irq_pkg::gie_cmd_t GIE_CMD_I,
  input wire logic CPU_ACK_I,
  input wire logic CPU_RET_I,
  output logic IRQ_O,
  output logic PUSH_STATE_O,
  output logic IN_SERVICE_O,
  output level_irq_pkg::service_t SERVICE_O,
  output logic [15:0] RESET_PC_O,
  output logic FAST_INT_EN_O,
  // program memory vector fetch
  output level_irq_pkg::vec_fetch_t VEC_FETCH_O,
  input wire logic [7:0] VEC_DATA_I
);
  import level_irq_pkg::*;

  // ---------------------------------------------------------------
  // source maps and priority ordering
  // ---------------------------------------------------------------
  localparam logic [14:0] LEVEL_MAP = `SRC_LEVEL_MAP;
  localparam logic [39:0] VECTOR_MAP = `SRC_VECTOR_MAP;
  localparam logic [4:0] HW_CLEAR = `SRC_HW_CLEAR;
  localparam int MAX_VEC = `MAX_VECTORS_PER_LEVEL; // in-level capacity; five used here

  // ranked list of levels, rank 0 in the low bits
  function automatic logic [23:0] level_order(input logic [7:0] prio);
    logic [5:0] grp_a;
    logic [5:0] sub_b;
    logic [5:0] sub_c;
    logic [8:0] grp_b;
    logic [8:0] grp_c;
    logic [23:0] order;
    grp_a = prio[0] ? {3'h0, 3'h1} : {3'h1, 3'h0}; // group a is levels 0,1
    sub_b = prio[3] ? {3'h3, 3'h4} : {3'h4, 3'h3};
    grp_b = prio[2] ? {3'h2, sub_b} : {sub_b, 3'h2}; // group b is levels 2-4
    sub_c = prio[6] ? {3'h6, 3'h7} : {3'h7, 3'h6};
    grp_c = prio[5] ? {3'h5, sub_c} : {sub_c, 3'h5}; // group c is levels 5-7
    case ({prio[7], prio[4], prio[1]}) // group order
      3'h1: order = {grp_a, grp_c, grp_b}; // b > c > a
      3'h2: order = {grp_c, grp_b, grp_a}; // a > b > c
      3'h3: order = {grp_c, grp_a, grp_b}; // b > a > c
      3'h4: order = {grp_b, grp_a, grp_c}; // c > a > b
      3'h5: order = {grp_a, grp_b, grp_c}; // c > b > a
      3'h6: order = {grp_b, grp_c, grp_a}; // a > c > b
      default: order = {grp_c, grp_b, grp_a}; // undefined codes fall back to a > b > c
    endcase
    return order;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] level_mask_ff;
  logic [7:0] level_prio_ff;
  logic gie_ff;
  logic fast_en_ff;
  logic [2:0] fast_lvl_ff;
  logic [4:0] src_en_ff;
  logic [4:0] pending_ff;
  logic [7:0] level_req_ff;
  svc_state_t state_ff;
  logic [2:0] svc_level_ff;
  logic [2:0] svc_src_ff;
  logic [7:0] svc_vec_ff;
  logic [7:0] addr_hi_ff;
  logic [15:0] last_addr_ff;
  logic push_ff;
  vec_fetch_t fetch_ff;
  service_t service_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] hrdata_ff;

  logic addr_phase;
  logic wr_data;
  logic [4:0] src_active;
  logic [7:0] level_live;
  logic [7:0] level_eligible;
  logic [23:0] order;
  logic win_found;
  logic [2:0] win_level;
  logic src_found;
  logic [2:0] win_src;
  logic [7:0] win_vec;
  logic grant;
  logic [31:0] rd_mux;

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  // address phase taken when selected, nonseq/seq and bus ready
  assign addr_phase = HSEL_I & HTRANS_I[1] & HREADY_I;
  assign wr_data = wr_pend_ff;
  assign HREADYOUT_O = 1'b1; // zero wait states
  assign HRESP_O = 1'b0; // always okay
  assign HRDATA_O = hrdata_ff;

  // latch write address for the data phase
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end
    else
    begin
      wr_pend_ff <= addr_phase & HWRITE_I;
      if (addr_phase)
        wr_addr_ff <= HADDR_I[7:0];
    end
  end

  // read mux; unmapped offsets read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (HADDR_I[7:0])
      `OFS_LEVEL_REQ: rd_mux = {24'h00_0000, level_req_ff}; // read-only
      `OFS_LEVEL_MASK: rd_mux = {24'h00_0000, level_mask_ff};
      `OFS_LEVEL_PRIO: rd_mux = {24'h00_0000, level_prio_ff};
      `OFS_SYS_MODE: rd_mux = {27'h000_0000, fast_lvl_ff, fast_en_ff, gie_ff};
      `OFS_SRC_CTRL: rd_mux = {19'h0_0000, pending_ff, 3'h0, src_en_ff};
      `OFS_SERVICE: rd_mux = {last_addr_ff, 5'h00, svc_src_ff, 4'h0,
                              (state_ff != ST_IDLE), svc_level_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data loaded at the address phase edge
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
      hrdata_ff <= 32'h0000_0000;
    else if (addr_phase & ~HWRITE_I)
      hrdata_ff <= rd_mux;
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // level mask and priority; software quiesces interrupts first
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      level_mask_ff <= `LEVEL_MASK_RST;
      level_prio_ff <= `LEVEL_PRIO_RST;
    end
    else if (wr_data)
    begin
      if (wr_addr_ff == `OFS_LEVEL_MASK)
        level_mask_ff <= HWDATA_I[7:0]; // bit n enables level n
      if (wr_addr_ff == `OFS_LEVEL_PRIO)
        level_prio_ff <= HWDATA_I[7:0]; // ordering only
    end
  end

  // system mode: global enable from instructions or direct write
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
      gie_ff <= 1'b0; // cleared; startup code must enable
    else if (GIE_CMD_I.set)
      gie_ff <= 1'b1; // enable instruction
    else if (GIE_CMD_I.clr)
      gie_ff <= 1'b0; // disable instruction
    else if (wr_data && wr_addr_ff == `OFS_SYS_MODE)
      gie_ff <= HWDATA_I[`MODE_GIE_BIT];
  end

  // fast interrupt enable and level select
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      fast_en_ff <= 1'b0;
      fast_lvl_ff <= 3'h0;
    end
    else if (wr_data && wr_addr_ff == `OFS_SYS_MODE)
    begin
      fast_en_ff <= HWDATA_I[`MODE_FAST_EN_BIT];
      fast_lvl_ff <= HWDATA_I[`MODE_FAST_LVL_LSB +: 3];
    end
  end

  // per-source enables
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
      src_en_ff <= `SRC_EN_RST;
    else if (wr_data && wr_addr_ff == `OFS_SRC_CTRL)
      src_en_ff <= HWDATA_I[4:0];
  end

  // ---------------------------------------------------------------
  // source pending bits
  // ---------------------------------------------------------------
  // writing 0 clears, 1 has no effect; a new event wins over any clear
  for (genvar s = 0; s < `SRC_CNT; s++)
  begin : g_src
    logic sw_clr;
    logic hw_clr;
    assign sw_clr = wr_data && (wr_addr_ff == `OFS_SRC_CTRL) && !HWDATA_I[`SRC_PEND_LSB + s];
    assign hw_clr = HW_CLEAR[s] && grant && (win_src == 3'(s));
    always_ff @(posedge CLK_SYS_I)
    begin
      if (RESET_I)
        pending_ff[s] <= 1'b0;
      else if (SRC_EVENT_I[s])
        pending_ff[s] <= 1'b1; // one source, one vector
      else if (sw_clr | hw_clr)
        pending_ff[s] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // level requests and selection
  // ---------------------------------------------------------------
  assign src_active = pending_ff & src_en_ff; // source enable gate

  // fold sources onto their levels; several may share one level
  always_comb
  begin
    level_live = 8'h00;
    for (int s = 0; s < `SRC_CNT; s++)
      if (src_active[s])
        level_live[LEVEL_MAP[3*s +: 3]] = 1'b1;
  end

  // level request register, polled even while globally disabled
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
      level_req_ff <= 8'h00;
    else
      level_req_ff <= level_live;
  end

  assign level_eligible = level_req_ff & level_mask_ff; // masked levels dropped
  assign order = level_order(level_prio_ff);

  // highest ranked eligible level
  always_comb
  begin
    win_found = 1'b0;
    win_level = 3'h0;
    for (int r = `LEVEL_CNT - 1; r >= 0; r--)
      if (level_eligible[order[3*r +: 3]])
      begin
        win_found = 1'b1;
        win_level = order[3*r +: 3];
      end
  end

  // lowest vector address among active sources of the winning level
  always_comb
  begin
    src_found = 1'b0;
    win_src = 3'h0;
    win_vec = 8'h00;
    for (int s = 0; s < `SRC_CNT; s++)
      if (src_active[s] && LEVEL_MAP[3*s +: 3] == win_level &&
          (!src_found || VECTOR_MAP[8*s +: 8] < win_vec))
      begin
        src_found = 1'b1;
        win_src = 3'(s);
        win_vec = VECTOR_MAP[8*s +: 8]; // fixed in-level order
      end
  end

  // request only when enabled, idle and an unmasked level is pending
  assign IRQ_O = gie_ff & win_found & src_found & (state_ff == ST_IDLE);
  assign grant = IRQ_O & CPU_ACK_I;

  // ---------------------------------------------------------------
  // service sequence
  // ---------------------------------------------------------------
  // grant, push, two byte fetches, hand-off, wait for return
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
      state_ff <= ST_IDLE;
    else
      case (state_ff)
        ST_IDLE: if (grant) state_ff <= ST_PUSH; // others blocked from here
        ST_PUSH: state_ff <= ST_RD_HI;
        ST_RD_HI: state_ff <= ST_RD_LO;
        ST_RD_LO: state_ff <= ST_LOAD;
        ST_LOAD: state_ff <= ST_SERVE;
        ST_SERVE: if (CPU_RET_I) state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
  end

  // granted level, source and vector
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      svc_level_ff <= 3'h0;
      svc_src_ff <= 3'h0;
      svc_vec_ff <= 8'h00;
    end
    else if (grant)
    begin
      svc_level_ff <= win_level;
      svc_src_ff <= win_src;
      svc_vec_ff <= win_vec;
    end
  end

  // push strobe for pc and flags, one cycle in the push state
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
      push_ff <= 1'b0;
    else
      push_ff <= grant;
  end

  // program memory reads inside the low 256 bytes
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
      fetch_ff <= '0;
    else if (state_ff == ST_PUSH)
      fetch_ff <= '{rd: 1'b1, addr: {8'h00, svc_vec_ff}};
    else if (state_ff == ST_RD_HI)
      fetch_ff <= '{rd: 1'b1, addr: {8'h00, 8'(svc_vec_ff + 8'h01)}};
    else
      fetch_ff <= '0;
  end

  // assemble handler address: first byte high, next byte low
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      addr_hi_ff <= 8'h00;
      last_addr_ff <= 16'h0000;
    end
    else if (state_ff == ST_RD_LO)
      addr_hi_ff <= VEC_DATA_I;
    else if (state_ff == ST_LOAD)
      last_addr_ff <= {addr_hi_ff, VEC_DATA_I};
  end

  // one-cycle hand-off of the handler address
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
      service_ff <= '0;
    else if (state_ff == ST_LOAD)
      service_ff <= '{valid: 1'b1, addr: {addr_hi_ff, VEC_DATA_I},
                      level: svc_level_ff, source: svc_src_ff};
    else
      service_ff.valid <= 1'b0;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign PUSH_STATE_O = push_ff;
  assign IN_SERVICE_O = (state_ff != ST_IDLE);
  assign SERVICE_O = service_ff;
  assign VEC_FETCH_O = fetch_ff;
  assign RESET_PC_O = `RESET_PC; // start above the vector area
  assign FAST_INT_EN_O = fast_en_ff;

endmodule

// ### level_irq_defines.svh
// level_irq_defines.svh: offsets, field positions, reset values and source maps
// assumes: included by its bare name; register offsets are byte addresses on AHB-Lite
//
// Notes on behaviour
// - eight level numbers 0 to 7 exist; only three carry sources here.
// - level numbers are names only; the priority register decides precedence.
// - a level may own zero to 128 vectors; in-level order is fixed.
// - five sources, each with its own vector address.
// - one vector may serve several sources; levels may mix vectors and sources.
// - contending levels are picked by the priority register ordering.
// - contending sources of one level: lowest vector address wins.
// - a grant blocks other interrupts and asks the core to push PC and flags.
// - handler address is the vector byte followed by the next byte, 16 bits.
// - all vectors live in the first 256 bytes of program memory.
// - execution starts at 0100H after reset.
// - enable/disable instructions set/clear mode bit 0; set means service by priority.
// - mask register bit per level; a masked level is not processed.
// - groups: A is levels 0-1, B levels 2-4, C levels 5-7.
// - level request register is read-only, one pending bit per level.
// - each source is also gated by its own enable bit.
// - a source pending bit is cleared at handler start by hardware or software.
// - the mode register also holds a fast interrupt enable.
// - priority bits 7, 4, 1 order groups A, B, C; 001B gives B>C>A.
// - mask bit n is level n; 0 masks, 1 enables.
// - reset clears the level request register.
`ifndef LEVEL_IRQ_DEFINES_SVH
`define LEVEL_IRQ_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OFS_LEVEL_REQ 8'h00
`define OFS_LEVEL_MASK 8'h04
`define OFS_LEVEL_PRIO 8'h08
`define OFS_SYS_MODE 8'h0c
`define OFS_SRC_CTRL 8'h10
`define OFS_SERVICE 8'h14

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define MODE_GIE_BIT 0
`define MODE_FAST_EN_BIT 1
`define MODE_FAST_LVL_LSB 2
`define SRC_PEND_LSB 8
`define LEVEL_MASK_RST 8'h00
`define LEVEL_PRIO_RST 8'h00
`define SRC_EN_RST 5'h00
`define RESET_PC 16'h0100
`define MAX_VECTORS_PER_LEVEL 128

// ---------------------------------------------------------------
// source maps: level (3 bits) and vector byte address (8 bits) per source
// ---------------------------------------------------------------
`define SRC_CNT 5
`define LEVEL_CNT 8
`define SRC_LEVEL_MAP {3'h2, 3'h1, 3'h1, 3'h0, 3'h0}
`define SRC_VECTOR_MAP {8'h08, 8'h06, 8'h04, 8'h02, 8'h00}
`define SRC_HW_CLEAR 5'h00

`endif

// ### level_irq_pkg.sv
// level_irq_pkg.sv: types shared by the interrupt level controller
// assumes: compiled before the controller module
package level_irq_pkg;

  // service sequence states
  typedef enum logic [2:0] {ST_IDLE, ST_PUSH, ST_RD_HI, ST_RD_LO, ST_LOAD, ST_SERVE} svc_state_t;

  // program memory read request
  typedef struct packed {
    logic rd;
    logic [15:0] addr;
  } vec_fetch_t;

  // handler hand-off to the core
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [2:0] level;
    logic [2:0] source;
  } service_t;

  // enable/disable instruction strobes
  typedef struct packed {
    logic set;
    logic clr;
  } gie_cmd_t;

endpackage

// ### level_irq_props.sv
// level_irq_props.sv: port assertions for the level interrupt controller
// assumes: bound to level_interrupt_controller; one clock, synchronous reset
`timescale 1ns/1ps
module level_irq_props
(
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  // core side
  input wire logic CPU_ACK_I,
  input wire logic CPU_RET_I,
  input wire logic IRQ_O,
  input wire logic PUSH_STATE_O,
  input wire logic IN_SERVICE_O,
  input wire level_irq_pkg::service_t SERVICE_O,
  input wire logic [15:0] RESET_PC_O,
  // vector fetch
  input wire level_irq_pkg::vec_fetch_t VEC_FETCH_O,
  input wire logic [7:0] VEC_DATA_I
);
  import level_irq_pkg::*;
  logic served_ff;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);

  // marks the part of a service after the handler address went out
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I || !IN_SERVICE_O)
      served_ff <= 1'b0;
    else if (SERVICE_O.valid)
      served_ff <= 1'b1;
  end

  property p_irq_blocked;
    IRQ_O |-> !IN_SERVICE_O;
  endproperty
  a_irq_blocked: assert property (p_irq_blocked) else $error("irq raised in service");
  property p_push;
    IRQ_O && CPU_ACK_I |=> PUSH_STATE_O && IN_SERVICE_O && !IRQ_O;
  endproperty
  a_push: assert property (p_push) else $error("no push after grant");
  property p_fetch;
    IRQ_O && CPU_ACK_I |-> ##2 VEC_FETCH_O.rd ##1 (VEC_FETCH_O.rd &&
      VEC_FETCH_O.addr == $past(VEC_FETCH_O.addr) + 16'h0001) ##1 !VEC_FETCH_O.rd;
  endproperty
  a_fetch: assert property (p_fetch) else $error("vector fetch pair wrong");
  property p_area;
    VEC_FETCH_O.rd |-> VEC_FETCH_O.addr[15:8] == 8'h00;
  endproperty
  a_area: assert property (p_area) else $error("vector fetch outside area");
  property p_valid;
    IRQ_O && CPU_ACK_I |-> (!SERVICE_O.valid) [*5] ##1 SERVICE_O.valid ##1 !SERVICE_O.valid;
  endproperty
  a_valid: assert property (p_valid) else $error("handler address late");
  property p_addr;
    SERVICE_O.valid |-> SERVICE_O.addr == {$past(VEC_DATA_I, 2), $past(VEC_DATA_I)};
  endproperty
  a_addr: assert property (p_addr) else $error("handler address not hi then lo");
  property p_hold;
    IN_SERVICE_O && !CPU_RET_I |=> IN_SERVICE_O;
  endproperty
  a_hold: assert property (p_hold) else $error("service ended early");
  property p_ret;
    served_ff && CPU_RET_I |=> !IN_SERVICE_O;
  endproperty
  a_ret: assert property (p_ret) else $error("return ignored");
  property p_pc;
    RESET_PC_O == 16'h0100;
  endproperty
  a_pc: assert property (p_pc) else $error("start address wrong");
endmodule

bind level_interrupt_controller level_irq_props i_props (
  .CLK_SYS_I(CLK_SYS_I),
  .RESET_I(RESET_I),
  .CPU_ACK_I(CPU_ACK_I),
  .CPU_RET_I(CPU_RET_I),
  .IRQ_O(IRQ_O),
  .PUSH_STATE_O(PUSH_STATE_O),
  .IN_SERVICE_O(IN_SERVICE_O),
  .SERVICE_O(SERVICE_O),
  .RESET_PC_O(RESET_PC_O),
  .VEC_FETCH_O(VEC_FETCH_O),
  .VEC_DATA_I(VEC_DATA_I)
);

// ### cpu_core_model.sv
// cpu_core_model.sv: core and program memory facing the controller
// assumes: same clock as the controller; drives right after rising edges
`timescale 1ns/1ps
module cpu_core_model
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // controller side
  input wire logic irq_i,
  input wire logic svc_valid_i,
  input wire level_irq_pkg::vec_fetch_t fetch_i,
  input wire logic [3:0] ack_wait_i,
  output logic ack_o,
  output logic ret_o,
  output logic [7:0] data_o
);
  import level_irq_pkg::*;
  logic [3:0] wait_ff;
  logic [3:0] ret_cnt_ff;

  // acknowledge once the request has stood ack_wait_i cycles
  always @(posedge clk_i)
  begin
    ack_o <= !rst_i && irq_i && !ack_o && (wait_ff >= ack_wait_i);
    if (rst_i || !irq_i || ack_o)
      wait_ff <= 4'h0;
    else if (wait_ff < ack_wait_i)
      wait_ff <= wait_ff + 4'h1;
  end

  // return a fixed span after the handler address arrives
  always @(posedge clk_i)
  begin
    ret_o <= !rst_i && !svc_valid_i && (ret_cnt_ff == 4'h1);
    if (rst_i)
      ret_cnt_ff <= 4'h0;
    else if (svc_valid_i)
      ret_cnt_ff <= 4'hc;
    else if (ret_cnt_ff != 4'h0)
      ret_cnt_ff <= ret_cnt_ff - 4'h1;
  end

  // vector bytes; an idle bus inverts its last value on every cycle
  always @(posedge clk_i)
  begin
    if (rst_i)
      data_o <= 8'h00;
    else if (fetch_i.rd)
      data_o <= fetch_i.addr[7:0] ^ 8'ha5;
    else
      data_o <= ~data_o;
  end
endmodule

// ### level_interrupt_controller_tb_top.sv
// level_interrupt_controller_tb_top.sv: self-checking bench for the controller
// assumes: cpu_core_model as core and memory; checker bound separately
`timescale 1ns/1ps
module level_interrupt_controller_tb_top;
  import level_irq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic hready, hresp, ack, ret, irq, push, insvc, fast, b;
  logic [4:0] src_ev = 5'h00;
  gie_cmd_t gie_cmd = '0;
  service_t svc;
  vec_fetch_t fetch;
  logic [15:0] rpc;
  logic [7:0] vdata;
  logic [3:0] ack_wait = 4'h0;
  logic [15:0] lfsr = 16'h0061;
  logic [2:0] c;
  logic [21:0] exp_q[$];
  int mismatches = 0;
  int total_checks = 0;
  int i;

  // clock
  always #5 clk = ~clk;

  level_interrupt_controller i_dut (.CLK_SYS_I(clk), .RESET_I(rst), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .SRC_EVENT_I(src_ev), .GIE_CMD_I(gie_cmd), .CPU_ACK_I(ack),
    .CPU_RET_I(ret), .IRQ_O(irq), .PUSH_STATE_O(push), .IN_SERVICE_O(insvc),
    .SERVICE_O(svc), .RESET_PC_O(rpc), .FAST_INT_EN_O(fast), .VEC_FETCH_O(fetch),
    .VEC_DATA_I(vdata));
  cpu_core_model i_core (.clk_i(clk), .rst_i(rst), .irq_i(irq), .svc_valid_i(svc.valid),
    .fetch_i(fetch), .ack_wait_i(ack_wait), .ack_o(ack), .ret_o(ret), .data_o(vdata));

  function automatic logic [15:0] nxt_lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic report_and_stop();
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one ahb-lite single word transfer, waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    bus(1'b0, a, 32'h0);
    chk(name, exp, q);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic pulse(input logic [4:0] ev);
    @(posedge clk);
    src_ev <= ev;
    @(posedge clk);
    src_ev <= 5'h00;
  endtask

  task automatic gie(input logic s);
    @(posedge clk);
    gie_cmd <= s ? 2'b10 : 2'b01;
    @(posedge clk);
    gie_cmd <= '0;
  endtask

  // enable, await the handler address, disable, clear only the served pending
  task automatic serve(input logic [2:0] s, input logic [2:0] l, input logic [7:0] v);
    int n;
    exp_q.push_back({v ^ 8'ha5, (v + 8'h01) ^ 8'ha5, l, s});
    gie(1'b1);
    for (n = 0; n < 200 && svc.valid !== 1'b1; n++) @(posedge clk);
    gie(1'b0);
    bus(1'b1, 8'h10, {19'h0, ~(5'h01 << s), 3'h0, 5'h1f});
    for (n = 0; n < 200 && insvc !== 1'b0; n++) @(posedge clk);
  endtask

  // compares each handler hand-off with the oldest expectation
  always @(posedge clk)
  begin
    if (svc.valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("service_unexpected", 32'h1, 32'h0);
      else
        chk("service", {10'h0, exp_q.pop_front()}, {10'h0, svc.addr, svc.level, svc.source});
    end
  end

  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    chk("reset_pc", 32'h100, {16'h0, rpc});
    rd(8'h00, 32'h0, "level_request");
    rd(8'h04, 32'h0, "level_mask");
    rd(8'h08, 32'h0, "level_priority");
    rd(8'h0c, 32'h0, "system_mode");
    rd(8'h20, 32'h0, "unmapped");
    bus(1'b1, 8'h04, 32'h07);
    bus(1'b1, 8'h10, 32'h1f);
    pulse(5'h17);
    repeat (3) @(posedge clk);
    chk("irq_while_disabled", 32'h0, {31'h0, irq});
    bus(1'b1, 8'h00, 32'h0);
    rd(8'h00, 32'h07, "level_request");
    bus(1'b1, 8'h10, {19'h0, 5'h1f, 3'h0, 5'h00});
    rd(8'h00, 32'h0, "level_request_gated");
    bus(1'b1, 8'h10, {19'h0, 5'h1f, 3'h0, 5'h1f});
    // random mode value, looked at one edge after it lands
    lfsr = nxt_lfsr(lfsr);
    bus(1'b1, 8'h0c, {27'h0, lfsr[4:1], 1'b0});
    @(posedge clk);
    chk("fast_enable", {31'h0, lfsr[1]}, {31'h0, fast});
    rd(8'h0c, {27'h0, lfsr[4:1], 1'b0}, "system_mode");
    bus(1'b1, 8'h0c, 32'h0);
    for (i = 0; i < 8; i++)
    begin
      c = i[2:0];
      b = (c == 3'h1 || c == 3'h3 || c == 3'h5);
      lfsr = nxt_lfsr(lfsr);
      ack_wait <= lfsr[3:0];
      bus(1'b1, 8'h08, {24'h0, c[2], 2'h0, c[1], 2'h0, c[0], c[2]});
      if (b)
        serve(3'h4, 3'h2, 8'h08);
      else if (c[2])
        serve(3'h2, 3'h1, 8'h04);
      else
        serve(3'h0, 3'h0, 8'h00);
      pulse(5'h15);
    end
    bus(1'b1, 8'h10, {19'h0, 5'h1e, 3'h0, 5'h1f});
    bus(1'b1, 8'h08, 32'h00);
    serve(3'h1, 3'h0, 8'h02);
    bus(1'b1, 8'h08, 32'h02);
    bus(1'b1, 8'h04, 32'h03);
    serve(3'h2, 3'h1, 8'h04);
    rd(8'h04, 32'h03, "level_mask");
    rd(8'h14, 32'ha1a0_0201, "service_status");
    chk("queue_left", 32'h0, exp_q.size());
    report_and_stop();
  end
endmodule
